// >>> design/gauge_core.sv
// battery gauge capacity, warning flags and load model core
// Contract
// - integrate sensed current into state of charge
// - full charge capacity under present load
// - report uncompensated nominal and full available
// - rise hold blocks soc rise while discharging
// - set initial flag below initial set
// - clear initial flag only above clear
// - set final flag below final set
// - final set of minus one disables setting
// - clear final flag above clear, if set
// - load mode selects current or power model
// - status bit mirrors load mode
// - current select 0 last run, else present
// - current select 1 present cycle average
// - select 2 average, 3 filtered current
// - select 4 design over five, 6 user
// - power select 0 last, 1 present
// - power select 2, 3 current times voltage
// - power select 4 energy/5, 6 user
// - reserve capacity with selectable compensation
// - relax when average below quit long enough
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module gauge_core
    import gauge_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [15:0] RD_DATA,
    input wire logic SAMPLE_VALID,
    input wire logic signed [15:0] CURRENT,
    input wire logic [15:0] VOLTAGE,
    output logic INIT_LOW_CAP,
    output logic FINAL_LOW_CAP,
    output logic LOAD_MODEL_STATUS,
    output logic RELAX,
    output logic UPDATE_DONE
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CALC = 3'b010,
        ST_FLAG = 3'b100
    } upd_t;

    function automatic logic [15:0] abs16(input logic signed [15:0] v);
        abs16 = v[15] ? 16'(-17'(v)) : 16'(v);
    endfunction

    function automatic logic [15:0] sat16(input logic signed [33:0] v);
        if (v < 34'sd0) begin
            sat16 = 16'h0000;
        end else if (v > 34'sd65535) begin
            sat16 = 16'hffff;
        end else begin
            sat16 = 16'(v);
        end
    endfunction

    function automatic logic [15:0] mw_of(input logic [15:0] i, input logic [15:0] v);
        mw_of = sat16(34'((32'(i) * 32'(v)) / 32'(UW_PER_MW)));
    endfunction

    function automatic logic [15:0] cfg_reset(input logic [3:0] idx);
        unique case (idx)
            CFG_CTRL: cfg_reset = RST_CTRL;
            CFG_INIT_SET: cfg_reset = RST_INIT_SET;
            CFG_INIT_CLR: cfg_reset = RST_INIT_CLR;
            CFG_FINAL_SET: cfg_reset = RST_FINAL_SET;
            CFG_FINAL_CLR: cfg_reset = RST_FINAL_CLR;
            CFG_DESIGN_CAP: cfg_reset = RST_DESIGN_CAP;
            CFG_DESIGN_ENERGY: cfg_reset = RST_DESIGN_ENERGY;
            CFG_QMAX: cfg_reset = RST_QMAX;
            CFG_IMPEDANCE: cfg_reset = RST_IMPEDANCE;
            CFG_QUIT_I: cfg_reset = RST_QUIT_I;
            CFG_RELAX_S: cfg_reset = RST_RELAX_S;
            CFG_DSG_THR: cfg_reset = RST_DSG_THR;
            default: cfg_reset = 16'h0000;
        endcase
    endfunction

    logic [15:0] cfg_q [CFG_N];
    upd_t st_q;
    logic signed [31:0] q_mas_q;
    logic signed [15:0] avg_i, lpf_i;
    logic [15:0] run_i_q, run_p_q, last_i_q, last_p_q, run_n_q, relax_cnt_q;
    logic last_valid_q, dsg_q, mode, dsg_now;
    logic [15:0] rm_q, fcc_q, nac_q, fac_q, soc_q, rate_q;

    logic [2:0] sel;
    logic [15:0] dsg_i, dsg_p, avg_mag, lpf_mag, q_mah;
    logic signed [31:0] q_max_mas, q_next;
    logic signed [17:0] run_div;

    assign mode = cfg_q[CFG_CTRL][CTRL_MODE_BIT];
    assign sel = cfg_q[CFG_CTRL][CTRL_SEL_LSB +: 3];
    assign avg_mag = abs16(avg_i);
    assign lpf_mag = abs16(lpf_i);
    assign dsg_i = CURRENT[15] ? abs16(CURRENT) : 16'h0000;
    assign dsg_p = mw_of(dsg_i, VOLTAGE);
    assign dsg_now = avg_i[15] && (avg_mag > cfg_q[CFG_DSG_THR]);
    assign q_max_mas = 32'(cfg_q[CFG_QMAX]) * 32'(MAS_PER_MAH);
    assign q_next = q_mas_q + 32'(CURRENT);
    assign q_mah = 16'(q_mas_q / 32'(MAS_PER_MAH));
    assign run_div = $signed({2'b00, run_n_q} + 18'h00001);

    // register writes
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int k = 0; k < CFG_N; k++) begin
                cfg_q[k] <= cfg_reset(4'(k));
            end
        end else if (WR_EN && ADDR[7:4] == 4'h0) begin
            cfg_q[ADDR[3:0]] <= WR_DATA;
        end
    end

    // register reads, data in the following cycle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RD_DATA <= 16'h0000;
        end else if (RD_EN) begin
            if (ADDR[7:4] == 4'h0) begin
                RD_DATA <= cfg_q[ADDR[3:0]];
            end else begin
                unique case (ADDR)
                    ADDR_STATUS: RD_DATA <= 16'({dsg_q, RELAX, mode, FINAL_LOW_CAP,
                                                INIT_LOW_CAP});
                    ADDR_RM: RD_DATA <= rm_q;
                    ADDR_FCC: RD_DATA <= fcc_q;
                    ADDR_NAC: RD_DATA <= nac_q;
                    ADDR_FAC: RD_DATA <= fac_q;
                    ADDR_SOC: RD_DATA <= soc_q;
                    ADDR_AVG_I: RD_DATA <= 16'(avg_i);
                    ADDR_RATE: RD_DATA <= rate_q;
                    default: RD_DATA <= 16'h0000;
                endcase
            end
        end else begin
            RD_DATA <= 16'h0000;
        end
    end

    // coulomb counter, clamped to empty and full
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            q_mas_q <= 32'sd0;
        end else if (SAMPLE_VALID) begin
            if (q_next < 32'sd0) begin
                q_mas_q <= 32'sd0;
            end else if (q_next > q_max_mas) begin
                q_mas_q <= q_max_mas;
            end else begin
                q_mas_q <= q_next;
            end
        end
    end

    gauge_lowpass #(.DIV(AVG_DIV)) u_avg (
        .clk(CLK),
        .rst_n(RST_N),
        .in_valid(SAMPLE_VALID),
        .x(CURRENT),
        .y(avg_i)
    );

    gauge_lowpass #(.DIV(LPF_DIV)) u_lpf (
        .clk(CLK),
        .rst_n(RST_N),
        .in_valid(SAMPLE_VALID),
        .x(avg_i),
        .y(lpf_i)
    );

    // discharge cycle running averages and last-run log
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            run_i_q <= 16'h0000;
            run_p_q <= 16'h0000;
            run_n_q <= 16'h0000;
            last_i_q <= 16'h0000;
            last_p_q <= 16'h0000;
            last_valid_q <= 1'b0;
            dsg_q <= 1'b0;
        end else if (SAMPLE_VALID) begin
            dsg_q <= dsg_now;
            if (dsg_now) begin
                run_n_q <= (run_n_q == 16'hffff) ? run_n_q : run_n_q + 16'h0001;
                run_i_q <= 16'($signed({1'b0, run_i_q}) + ($signed({1'b0, dsg_i}) -
                               $signed({1'b0, run_i_q})) / run_div);
                run_p_q <= 16'($signed({1'b0, run_p_q}) + ($signed({1'b0, dsg_p}) -
                               $signed({1'b0, run_p_q})) / run_div);
            end else if (run_n_q != 16'h0000) begin
                last_i_q <= run_i_q;
                last_p_q <= run_p_q;
                last_valid_q <= 1'b1;
                run_n_q <= 16'h0000;
                run_i_q <= 16'h0000;
                run_p_q <= 16'h0000;
            end
        end
    end

    // relax detection on average current magnitude
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            relax_cnt_q <= 16'h0000;
            RELAX <= 1'b0;
        end else if (SAMPLE_VALID) begin
            if (avg_mag < cfg_q[CFG_QUIT_I]) begin
                if (relax_cnt_q != 16'hffff) begin
                    relax_cnt_q <= relax_cnt_q + 16'h0001;
                end
                if (relax_cnt_q + 16'h0001 >= cfg_q[CFG_RELAX_S]) begin
                    RELAX <= 1'b1;
                end
            end else begin
                relax_cnt_q <= 16'h0000;
                RELAX <= 1'b0;
            end
        end
    end

    // load rate per model and select
    logic [15:0] rate_d, loss, res_eff, soc_d, rm_d, fcc_d;
    logic [31:0] prod;
    always_comb begin
        rate_d = run_i_q;
        if (mode == MODE_CURRENT) begin
            unique case (sel)
                SEL_LAST: rate_d = last_valid_q ? last_i_q : run_i_q;
                SEL_RUN: rate_d = run_i_q;
                SEL_AVG: rate_d = avg_mag;
                SEL_LPF: rate_d = lpf_mag;
                SEL_DESIGN: rate_d = cfg_q[CFG_DESIGN_CAP] / 16'(C_RATE_DIV);
                SEL_USER: rate_d = cfg_q[CFG_USER_I];
                default: rate_d = run_i_q;
            endcase
        end else begin
            unique case (sel)
                SEL_LAST: rate_d = last_p_q;
                SEL_RUN: rate_d = run_p_q;
                SEL_AVG: rate_d = mw_of(avg_mag, VOLTAGE);
                SEL_LPF: rate_d = mw_of(lpf_mag, VOLTAGE);
                SEL_DESIGN: rate_d = cfg_q[CFG_DESIGN_ENERGY] / 16'(C_RATE_DIV);
                SEL_USER: rate_d = cfg_q[CFG_USER_P];
                default: rate_d = last_p_q;
            endcase
        end
    end

    assign prod = 32'(rate_d) * 32'(cfg_q[CFG_IMPEDANCE]);
    assign loss = sat16(34'(prod >> LOSS_SHIFT));
    assign res_eff = cfg_q[CFG_CTRL][CTRL_RESCOMP_BIT] ?
                     sat16(34'(cfg_q[CFG_RESERVE]) + 34'(prod >> RES_LOSS_SHIFT)) :
                     cfg_q[CFG_RESERVE];

    assign rm_d = sat16(34'(q_mah) - 34'(loss) - 34'(res_eff));
    assign fcc_d = sat16(34'(cfg_q[CFG_QMAX]) - 34'(loss) - 34'(res_eff));
    assign soc_d = (fcc_d == 16'h0000) ? 16'h0000 :
                   ((rm_d >= fcc_d) ? 16'(SOC_FULL) :
                   16'((32'(rm_d) * 32'(SOC_FULL)) / 32'(fcc_d)));

    // update sequencer: sample, compute, flags
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= ST_IDLE;
            UPDATE_DONE <= 1'b0;
        end else begin
            UPDATE_DONE <= (st_q == ST_FLAG);
            unique case (st_q)
                ST_IDLE: st_q <= SAMPLE_VALID ? ST_CALC : ST_IDLE;
                ST_CALC: st_q <= ST_FLAG;
                ST_FLAG: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // capacity results
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rm_q <= 16'h0000;
            fcc_q <= 16'h0000;
            nac_q <= 16'h0000;
            fac_q <= 16'h0000;
            soc_q <= 16'h0000;
            rate_q <= 16'h0000;
        end else if (st_q == ST_CALC) begin
            rate_q <= rate_d;
            rm_q <= rm_d;
            fcc_q <= fcc_d;
            nac_q <= sat16(34'(q_mah) - 34'(cfg_q[CFG_RESERVE]));
            fac_q <= sat16(34'(cfg_q[CFG_QMAX]) - 34'(cfg_q[CFG_RESERVE]));
            if (!(cfg_q[CFG_CTRL][CTRL_HOLD_BIT] && dsg_q && soc_d > soc_q)) begin
                soc_q <= soc_d;
            end
        end
    end

    // low capacity warnings with hysteresis
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            INIT_LOW_CAP <= 1'b0;
            FINAL_LOW_CAP <= 1'b0;
        end else if (st_q == ST_FLAG) begin
            if (rm_q < cfg_q[CFG_INIT_SET]) begin
                INIT_LOW_CAP <= 1'b1;
            end else if (rm_q > cfg_q[CFG_INIT_CLR]) begin
                INIT_LOW_CAP <= 1'b0;
            end
            if (cfg_q[CFG_FINAL_SET] != FINAL_OFF && rm_q < cfg_q[CFG_FINAL_SET]) begin
                FINAL_LOW_CAP <= 1'b1;
            end else if (FINAL_LOW_CAP && rm_q > cfg_q[CFG_FINAL_CLR]) begin
                FINAL_LOW_CAP <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            LOAD_MODEL_STATUS <= 1'b0;
        end else begin
            LOAD_MODEL_STATUS <= mode;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    chk_init_set: assert property (st_q == ST_FLAG && rm_q < cfg_q[CFG_INIT_SET]
        |=> INIT_LOW_CAP) else $error("initial flag not set");
    chk_init_hyst: assert property (st_q == ST_FLAG && rm_q >= cfg_q[CFG_INIT_SET]
        && rm_q <= cfg_q[CFG_INIT_CLR] |=> $stable(INIT_LOW_CAP))
        else $error("initial flag moved inside band");
    chk_init_clear: assert property (st_q == ST_FLAG && rm_q >= cfg_q[CFG_INIT_SET]
        && rm_q > cfg_q[CFG_INIT_CLR] |=> !INIT_LOW_CAP)
        else $error("initial flag not cleared");
    chk_final_set: assert property (st_q == ST_FLAG && cfg_q[CFG_FINAL_SET] != FINAL_OFF
        && rm_q < cfg_q[CFG_FINAL_SET] |=> FINAL_LOW_CAP)
        else $error("final flag not set");
    chk_final_off: assert property (cfg_q[CFG_FINAL_SET] == FINAL_OFF && !FINAL_LOW_CAP
        |=> !FINAL_LOW_CAP) else $error("final flag set while disabled");
    chk_final_clear: assert property (st_q == ST_FLAG && FINAL_LOW_CAP
        && !(cfg_q[CFG_FINAL_SET] != FINAL_OFF && rm_q < cfg_q[CFG_FINAL_SET])
        && rm_q > cfg_q[CFG_FINAL_CLR] |=> !FINAL_LOW_CAP)
        else $error("final flag not cleared");
    chk_mode_mirror: assert property (##1 LOAD_MODEL_STATUS == $past(mode))
        else $error("load model status lags");
    chk_rise_hold: assert property (st_q == ST_CALC && cfg_q[CFG_CTRL][CTRL_HOLD_BIT]
        && dsg_q |=> soc_q <= $past(soc_q)) else $error("soc rose under hold");
    chk_user_rate: assert property (st_q == ST_CALC && mode == MODE_CURRENT
        && sel == SEL_USER |=> rate_q == $past(cfg_q[CFG_USER_I]))
        else $error("user current rate not used");
    chk_flag_latency: assert property (SAMPLE_VALID && st_q == ST_IDLE
        |=> st_q == ST_CALC ##1 st_q == ST_FLAG ##1 UPDATE_DONE)
        else $error("update sequence broken");
    chk_relax_level: assert property (RELAX && $rose(RELAX) |-> $past(avg_mag)
        < $past(cfg_q[CFG_QUIT_I])) else $error("relax without low current");
    chk_integrate: assert property (SAMPLE_VALID && !CURRENT[15] && q_next <= q_max_mas
        |=> q_mas_q == $past(q_next)) else $error("charge not integrated");

    cov_init_warn: cover property ($rose(INIT_LOW_CAP));
    cov_final_warn: cover property ($rose(FINAL_LOW_CAP));
    cov_relax: cover property ($rose(RELAX));
    cov_power_mode: cover property (st_q == ST_CALC && mode == MODE_POWER);
endmodule
`default_nettype wire

// >>> design/gauge_lowpass.sv
// first-order low-pass filter updated on each sample
`timescale 1ns/1ps
`default_nettype none
module gauge_lowpass #(
    parameter int DIV = 14
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic signed [15:0] x,
    output logic signed [15:0] y
);
    logic signed [16:0] step;
    assign step = (17'(x) - 17'(y)) / 17'(DIV);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            y <= 16'sh0000;
        end else if (in_valid) begin
            y <= 16'(17'(y) + step);
        end
    end
endmodule
`default_nettype wire

// >>> design/gauge_pkg.sv
// shared constants for the gauge capacity core
package gauge_pkg;
    localparam int DW = 16;
    localparam int AW = 8;
    localparam int CFG_N = 16;
    // configuration word indices
    localparam logic [3:0] CFG_CTRL = 4'h0;
    localparam logic [3:0] CFG_INIT_SET = 4'h1;
    localparam logic [3:0] CFG_INIT_CLR = 4'h2;
    localparam logic [3:0] CFG_FINAL_SET = 4'h3;
    localparam logic [3:0] CFG_FINAL_CLR = 4'h4;
    localparam logic [3:0] CFG_DESIGN_CAP = 4'h5;
    localparam logic [3:0] CFG_DESIGN_ENERGY = 4'h6;
    localparam logic [3:0] CFG_USER_I = 4'h7;
    localparam logic [3:0] CFG_USER_P = 4'h8;
    localparam logic [3:0] CFG_RESERVE = 4'h9;
    localparam logic [3:0] CFG_QMAX = 4'ha;
    localparam logic [3:0] CFG_IMPEDANCE = 4'hb;
    localparam logic [3:0] CFG_QUIT_I = 4'hc;
    localparam logic [3:0] CFG_RELAX_S = 4'hd;
    localparam logic [3:0] CFG_DSG_THR = 4'he;
    // read-only result addresses
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_RM = 8'h11;
    localparam logic [7:0] ADDR_FCC = 8'h12;
    localparam logic [7:0] ADDR_NAC = 8'h13;
    localparam logic [7:0] ADDR_FAC = 8'h14;
    localparam logic [7:0] ADDR_SOC = 8'h15;
    localparam logic [7:0] ADDR_AVG_I = 8'h16;
    localparam logic [7:0] ADDR_RATE = 8'h17;
    // control word fields
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_SEL_LSB = 1;
    localparam int CTRL_HOLD_BIT = 4;
    localparam int CTRL_RESCOMP_BIT = 5;
    // status word fields
    localparam int ST_INIT_BIT = 0;
    localparam int ST_FINAL_BIT = 1;
    localparam int ST_MODE_BIT = 2;
    localparam int ST_RELAX_BIT = 3;
    localparam int ST_DSG_BIT = 4;
    // reset values
    localparam logic [15:0] RST_CTRL = 16'h0002;
    localparam logic [15:0] RST_INIT_SET = 16'h0096;
    localparam logic [15:0] RST_INIT_CLR = 16'h00af;
    localparam logic [15:0] RST_FINAL_SET = 16'h004b;
    localparam logic [15:0] RST_FINAL_CLR = 16'h0064;
    localparam logic [15:0] RST_DESIGN_CAP = 16'h03e8;
    localparam logic [15:0] RST_DESIGN_ENERGY = 16'h0e10;
    localparam logic [15:0] RST_QMAX = 16'h03e8;
    localparam logic [15:0] RST_IMPEDANCE = 16'h0040;
    localparam logic [15:0] RST_QUIT_I = 16'h000a;
    localparam logic [15:0] RST_RELAX_S = 16'h003c;
    localparam logic [15:0] RST_DSG_THR = 16'h003c;
    localparam logic [15:0] FINAL_OFF = 16'hffff;
    // load modes and selects
    localparam logic MODE_CURRENT = 1'b0;
    localparam logic MODE_POWER = 1'b1;
    localparam logic [2:0] SEL_LAST = 3'h0;
    localparam logic [2:0] SEL_RUN = 3'h1;
    localparam logic [2:0] SEL_AVG = 3'h2;
    localparam logic [2:0] SEL_LPF = 3'h3;
    localparam logic [2:0] SEL_DESIGN = 3'h4;
    localparam logic [2:0] SEL_USER = 3'h6;
    // timing and arithmetic
    localparam int SAMPLE_PERIOD_S = 1;
    localparam int LPF_TAU_S = 14;
    localparam int LPF_DIV = LPF_TAU_S / SAMPLE_PERIOD_S;
    localparam int AVG_DIV = 4;
    localparam int MAS_PER_MAH = 3600 * SAMPLE_PERIOD_S;
    localparam int UW_PER_MW = 1000;
    localparam int C_RATE_DIV = 5;
    localparam int LOSS_SHIFT = 10;
    localparam int RES_LOSS_SHIFT = 11;
    localparam int SOC_FULL = 100;
endpackage

// >>> dv/gauge_core_tb.sv
// self-checking testbench for the gauge capacity core
`timescale 1ns/1ps
`default_nettype none
module gauge_core_tb;
    import gauge_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sample_valid = 1'b0;
    logic signed [15:0] current = 16'sh0000;
    logic [15:0] voltage = 16'h0e10;
    logic [7:0] addr;
    logic [15:0] wr_data, rd_data;
    logic wr_en, rd_en, init_low, final_low, mode_stat, relax, upd_done;
    int err_total = 0;
    int cmp_count = 0;
    int q_mah = 0;
    logic ini_exp = 1'b0;
    logic fin_exp = 1'b0;
    logic [15:0] fset = 16'h004b;

    always #25 clk = ~clk;

    gauge_host_model host_u (.clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data));

    gauge_core dut_u (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wr_data),
        .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .SAMPLE_VALID(sample_valid),
        .CURRENT(current), .VOLTAGE(voltage), .INIT_LOW_CAP(init_low),
        .FINAL_LOW_CAP(final_low), .LOAD_MODEL_STATUS(mode_stat), .RELAX(relax),
        .UPDATE_DONE(upd_done));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        host_u.rd(a, d);
        check(what, exp, d);
    endtask

    // one measurement, then wait for the update to finish
    task automatic sample(input logic signed [15:0] i);
        int n;
        @(posedge clk);
        sample_valid <= 1'b1;
        current <= i;
        @(posedge clk);
        sample_valid <= 1'b0;
        current <= ~i;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (upd_done !== 1'b1 && n < 8);
        check("update_done", 16'h0001, {15'h0000, upd_done});
    endtask

    // sample plus flag model; rate and reserve are zero so remaining equals charge
    task automatic step(input logic signed [15:0] i);
        sample(i);
        q_mah = q_mah + i / 3600;
        if (q_mah < 0) q_mah = 0;
        if (q_mah < 150) ini_exp = 1'b1;
        else if (q_mah > 175) ini_exp = 1'b0;
        if (fset != 16'hffff && q_mah < int'(fset)) fin_exp = 1'b1;
        else if (q_mah > 100) fin_exp = 1'b0;
        check("init_low", {15'h0000, ini_exp}, {15'h0000, init_low});
        check("final_low", {15'h0000, fin_exp}, {15'h0000, final_low});
        rdchk(ADDR_RM, 16'(q_mah), "remaining");
    endtask

    task automatic regs_and_relax();
        rdchk(8'(CFG_CTRL), RST_CTRL, "ctrl reset");
        rdchk(8'(CFG_FINAL_SET), RST_FINAL_SET, "final set reset");
        rdchk(8'h20, 16'h0000, "unmapped");
        host_u.wr(8'h0f, 16'h5a5a);
        rdchk(8'h0f, 16'h5a5a, "spare");
        host_u.wr(8'(CFG_RELAX_S), 16'h0003);
        for (int k = 1; k <= 3; k++) begin
            step(16'sh0000);
            check("relax", {15'h0000, k == 3}, {15'h0000, relax});
        end
    endtask

    task automatic rates();
        logic [15:0] ctrl_tab [4] = '{16'h0008, 16'h000c, 16'h0009, 16'h000d};
        logic [15:0] rate_tab [4] = '{16'h00c8, 16'h0123, 16'h02d0, 16'h0045};
        host_u.wr(8'(CFG_USER_I), 16'h0123);
        host_u.wr(8'(CFG_USER_P), 16'h0045);
        for (int k = 0; k < 4; k++) begin
            host_u.wr(8'(CFG_CTRL), ctrl_tab[k]);
            sample(16'sh0000);
            rdchk(ADDR_RATE, rate_tab[k], "rate");
            check("mode status", {15'h0000, ctrl_tab[k][0]}, {15'h0000, mode_stat});
            rdchk(ADDR_STATUS, 16'h000b | (16'(ctrl_tab[k][0]) << 2), "status mode");
        end
        host_u.wr(8'(CFG_CTRL), 16'h000c);
        host_u.wr(8'(CFG_USER_I), 16'h0000);
    endtask

    // loss 16 and loaded reserve 18, then unloaded reserve 10
    task automatic reserve();
        host_u.wr(8'(CFG_USER_I), 16'h0100);
        host_u.wr(8'(CFG_RESERVE), 16'h000a);
        host_u.wr(8'(CFG_CTRL), 16'h002c);
        sample(16'sh0000);
        rdchk(ADDR_RM, 16'h00d1, "rm loaded");
        rdchk(ADDR_FCC, 16'h03c6, "fcc loaded");
        rdchk(ADDR_NAC, 16'h00e9, "nac");
        rdchk(ADDR_FAC, 16'h03de, "fac");
        rdchk(ADDR_SOC, 16'h0015, "soc");
        host_u.wr(8'(CFG_CTRL), 16'h000c);
        sample(16'sh0000);
        rdchk(ADDR_RM, 16'h00d9, "rm unloaded");
        rdchk(ADDR_FCC, 16'h03ce, "fcc unloaded");
        host_u.wr(8'(CFG_USER_I), 16'h0000);
        host_u.wr(8'(CFG_RESERVE), 16'h0000);
    endtask

    // while discharging with hold set, soc may fall but not rise
    task automatic hold_check();
        host_u.wr(8'(CFG_USER_I), 16'h0400);
        host_u.wr(8'(CFG_CTRL), 16'h001c);
        sample(16'sh0000);
        rdchk(ADDR_SOC, 16'h0006, "soc loaded");
        rdchk(ADDR_STATUS, 16'h0011, "status discharging");
        host_u.wr(8'(CFG_USER_I), 16'h0000);
        sample(16'sh0000);
        rdchk(ADDR_SOC, 16'h0006, "soc held");
        host_u.wr(8'(CFG_CTRL), 16'h000c);
        sample(16'sh0000);
        rdchk(ADDR_SOC, 16'h000c, "soc released");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #(50 * 40000);
        err_total++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        regs_and_relax();
        rates();
        for (int k = 0; k < 27; k++) step(16'sh7e90);
        check("relax off", 16'h0000, {15'h0000, relax});
        reserve();
        fset = 16'hffff;
        host_u.wr(8'(CFG_FINAL_SET), fset);
        for (int k = 0; k < 13; k++) step(-16'sh7e90);
        hold_check();
        for (int k = 0; k < 14; k++) step(-16'sh7e90);
        fset = 16'h004b;
        host_u.wr(8'(CFG_FINAL_SET), fset);
        step(16'sh0000);
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> dv/gauge_host_model.sv
// host model that reaches the gauge registers over the plain register port
`timescale 1ns/1ps
`default_nettype none
module gauge_host_model (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [15:0] wr_data,
    output logic wr_en,
    output logic rd_en,
    input wire logic [15:0] rd_data
);
    initial begin
        addr = 8'h00;
        wr_data = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    // one-cycle write strobe, data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_data <= ~d;
        addr <= ~a;
    endtask

    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        addr <= ~a;
        #1;
        d = rd_data;
    endtask
endmodule
`default_nettype wire
